// >>> iprc_chk_checker.sv
// Checker on the bank ports: APB decode and winner outputs.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module iprc_chk #(parameter NUM_IRQ = 32) (
  input wire logic clk, rst_b, psel, penable, pwrite, pslverr, win_valid_r,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic [NUM_IRQ-1:0] irq_enable, irq_pending,
  input wire logic [4:0] win_id_r,
  input wire logic [7:0] win_level_r);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Access phase, mapped aligned word, live requests
  wire acc = psel && penable;
  wire hit = paddr >= 12'h400 && paddr <= 12'h420 && paddr[1:0] == 2'h0;
  wire [NUM_IRQ-1:0] pe = irq_enable & irq_pending;
  a_err_unmapped: assert property (acc && !hit |-> pslverr && prdata == 32'h0) else $error("bad addr");
  a_err_mapped: assert property (acc && hit |-> !pslverr) else $error("refused");
  a_rd_idle: assert property (!acc || pwrite |-> prdata == 32'h0) else $error("stray data");
  a_rsvd_zero: assert property (acc && paddr < 12'h420 |-> (prdata & 32'h3F3F3F3F) == 32'h0)
    else $error("reserved set");
  a_valid_cause: assert property ($past(rst_b) |-> win_valid_r == |$past(pe)) else $error("valid");
  a_winner_live: assert property ($past(rst_b) && win_valid_r |-> $past(pe) >> win_id_r & 1)
    else $error("dead winner");
  a_level_grid: assert property (win_valid_r |-> win_level_r[5:0] == 6'h0) else $error("grid");
  a_reset_clear: assert property ($rose(rst_b) |-> !win_valid_r && win_id_r == 5'h0 && win_level_r == 8'h0)
    else $error("not cleared");
endmodule // iprc_chk
bind iprc_priority_bank iprc_chk #(.NUM_IRQ(NUM_IRQ)) i_iprc_chk (.clk, .rst_b, .psel, .penable, .pwrite,
  .pslverr, .win_valid_r, .paddr, .prdata, .irq_enable, .irq_pending, .win_id_r, .win_level_r);

// >>> iprc_core_model.sv
// Core-side model: holds pending lines and takes winners.
// Assumes the bench raises lines and pulses take.
`timescale 1ns/1ps
module iprc_core_model (
  input wire logic clk, take, win_valid_r,
  input wire logic [31:0] raise,
  input wire logic [4:0] win_id_r,
  output logic [31:0] irq_pending = 32'h0);
  // Only the taken line leaves; the rest wait as long as the core stalls
  always @(posedge clk) begin
    irq_pending <= irq_pending | raise;
    if (take && win_valid_r) irq_pending[win_id_r] <= 1'b0;
  end
endmodule // iprc_core_model

// >>> iprc_defs.vh
// Constants for the interrupt priority register bank and its selector.
// Assumes inclusion by bare name from the design files of this block.
`ifndef IPRC_DEFS_VH
`define IPRC_DEFS_VH

// ------------------------------------------------------------
// Register map (byte addresses inside the bank)
// ------------------------------------------------------------
`define IPRC_OFS_GROUP0    12'h400
`define IPRC_OFS_GROUP7    12'h41C
`define IPRC_OFS_STATUS    12'h420
`define IPRC_ADDR_W        12
`define IPRC_IDX_LSB       2
`define IPRC_IDX_W         3

// ------------------------------------------------------------
// Field layout
// ------------------------------------------------------------
`define IPRC_FIELD_W       8
`define IPRC_LVL_W         2
`define IPRC_LVL_LSB       6
`define IPRC_FIELDS_PER    4
`define IPRC_RST_LVL       2'h0
`define IPRC_WORD_ZERO     32'h0000_0000

// Status register layout: valid bit and winning number
`define IPRC_ST_VALID      31
`define IPRC_ST_LVL_LSB    8
`define IPRC_ST_ID_W       5

`endif

// >>> iprc_level_ram.v
// Level store: one two-bit level per interrupt, read and written per word.
// Assumes one clock, synchronous active-low reset, word accesses only.
`timescale 1ns/1ps
`include "iprc_defs.vh"

module iprc_level_ram #(
  parameter NUM_IRQ = 32
) (
  input  wire                      clk,
  input  wire                      rst_b,
  input  wire                      wr_en,
  input  wire [`IPRC_IDX_W-1:0]    wr_idx,
  input  wire [31:0]               wr_data,
  input  wire [`IPRC_IDX_W-1:0]    rd_idx,
  output reg  [31:0]               rd_data_r,
  output wire [NUM_IRQ*2-1:0]      levels
);

  reg [1:0] lvl_r [0:NUM_IRQ-1];
  integer   i;

  // ------------------------------------------------------------
  // Storage: only bits 7:6 of each byte are kept
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_b) begin
      for (i = 0; i < NUM_IRQ; i = i + 1) begin
        lvl_r[i] <= `IPRC_RST_LVL;
      end
    end else if (wr_en) begin
      for (i = 0; i < `IPRC_FIELDS_PER; i = i + 1) begin
        if (wr_idx * `IPRC_FIELDS_PER + i < NUM_IRQ) begin
          // Lowest interrupt in the lowest byte; low six bits dropped
          lvl_r[wr_idx*`IPRC_FIELDS_PER+i] <=
            wr_data[i*`IPRC_FIELD_W+`IPRC_LVL_LSB +: `IPRC_LVL_W];
        end
      end
    end
  end

  // Registered read word; unimplemented bits come back as zero
  always @(posedge clk) begin
    if (!rst_b) begin
      rd_data_r <= `IPRC_WORD_ZERO;
    end else begin
      rd_data_r <= `IPRC_WORD_ZERO;
      for (i = 0; i < `IPRC_FIELDS_PER; i = i + 1) begin
        if (rd_idx * `IPRC_FIELDS_PER + i < NUM_IRQ) begin
          rd_data_r[i*`IPRC_FIELD_W+`IPRC_LVL_LSB +: `IPRC_LVL_W] <=
            lvl_r[rd_idx*`IPRC_FIELDS_PER+i];
        end
      end
    end
  end

  // Flat view of all levels for the selector
  genvar g;
  generate
    for (g = 0; g < NUM_IRQ; g = g + 1) begin : g_flat
      assign levels[g*2 +: 2] = lvl_r[g];
    end
  endgenerate

endmodule // iprc_level_ram

// >>> iprc_priority_bank.v
// Interrupt priority register bank with APB slave and winner selection.
// Assumes an APB master on clk; enable and pending come from elsewhere.
//
// Behaviour
// - Each interrupt has its own 8-bit priority field, four to a 32-bit register.
// - There are as many registers as needed for the interrupts, eight for 32.
// - Only bits 31:30, 23:22, 15:14 and 7:6 of each register are stored.
// - A smaller level value means a more urgent interrupt.
// - All levels are zero after reset.
// - Register k holds interrupts 4k to 4k+3, lowest number in bits 7:6.
// - The usable levels are 0, 64, 128 and 192, with 0 most urgent.
// - Only pending and enabled interrupts may win; disabled ones never do.
`timescale 1ns/1ps
`include "iprc_defs.vh"

module iprc_priority_bank #(
  parameter NUM_IRQ = 32
) (
  input  wire                      clk,
  input  wire                      rst_b,
  input  wire                      psel,
  input  wire                      penable,
  input  wire                      pwrite,
  input  wire [`IPRC_ADDR_W-1:0]   paddr,
  input  wire [31:0]               pwdata,
  output reg  [31:0]               prdata,
  output wire                      pready,
  output wire                      pslverr,
  input  wire [NUM_IRQ-1:0]        irq_enable,
  input  wire [NUM_IRQ-1:0]        irq_pending,
  output reg                       win_valid_r,
  output reg  [`IPRC_ST_ID_W-1:0]  win_id_r,
  output reg  [`IPRC_FIELD_W-1:0]  win_level_r
);

  // Number of implemented registers follows the interrupt count
  localparam NUM_REG = (NUM_IRQ + `IPRC_FIELDS_PER - 1) / `IPRC_FIELDS_PER;

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  // End offset kept at address width on purpose; the bank never wraps the 12-bit map
  localparam [31:0]       OFS_END_W = `IPRC_OFS_GROUP0 + NUM_REG * (1 << `IPRC_IDX_LSB);
  wire [`IPRC_ADDR_W-1:0] ofs_end  = OFS_END_W[`IPRC_ADDR_W-1:0];
  wire                    hit_pri  = (paddr >= `IPRC_OFS_GROUP0) && (paddr < ofs_end) &&
                                     (paddr[1:0] == 2'h0);
  wire                    hit_st   = (paddr == `IPRC_OFS_STATUS);
  wire [`IPRC_IDX_W-1:0]  idx      = paddr[`IPRC_IDX_LSB +: `IPRC_IDX_W];
  wire [31:0]             ram_rd;
  wire [NUM_IRQ*2-1:0]    levels;

  // Zero wait states: the store word is registered at the setup edge
  assign pready  = 1'b1;
  // Unmapped or misaligned addresses are flagged; word-only bank
  assign pslverr = psel && penable && !hit_pri && !hit_st;

  wire wr_pri = psel && penable && pwrite && hit_pri;

  iprc_level_ram #(
    .NUM_IRQ (NUM_IRQ)
  ) u_ram (
    .clk       (clk),
    .rst_b     (rst_b),
    .wr_en     (wr_pri),
    .wr_idx    (idx),
    .wr_data   (pwdata),
    .rd_idx    (idx),
    .rd_data_r (ram_rd),
    .levels    (levels)
  );

  // Read mux; ram word is registered at the setup edge
  always @* begin
    prdata = `IPRC_WORD_ZERO;
    if (psel && penable && !pwrite) begin
      if (hit_pri) begin
        prdata = ram_rd;
      end else if (hit_st) begin
        prdata[`IPRC_ST_VALID]                          = win_valid_r;
        prdata[`IPRC_ST_LVL_LSB +: `IPRC_FIELD_W]       = win_level_r;
        prdata[`IPRC_ST_ID_W-1:0]                       = win_id_r;
      end
    end
  end

  // ------------------------------------------------------------
  // Winner selection
  // ------------------------------------------------------------
  // Strict compare keeps the earlier (lower numbered) candidate on ties
  reg                     best_v;
  reg [`IPRC_ST_ID_W-1:0] best_id;
  reg [1:0]               best_lvl;
  integer                 n;

  always @* begin
    best_v   = 1'b0;
    best_id  = {`IPRC_ST_ID_W{1'b0}};
    best_lvl = 2'h3;
    for (n = 0; n < NUM_IRQ; n = n + 1) begin
      if (irq_pending[n] && irq_enable[n]) begin
        if (!best_v || (levels[n*2 +: 2] < best_lvl)) begin
          best_v   = 1'b1;
          best_id  = n[`IPRC_ST_ID_W-1:0];
          best_lvl = levels[n*2 +: 2];
        end
      end
    end
  end

  // Winner is registered; level scaled to 0/64/128/192
  always @(posedge clk) begin
    if (!rst_b) begin
      win_valid_r <= 1'b0;
      win_id_r    <= {`IPRC_ST_ID_W{1'b0}};
      win_level_r <= {`IPRC_FIELD_W{1'b0}};
    end else begin
      win_valid_r <= best_v;
      win_id_r    <= best_id;
      win_level_r <= {best_lvl, 6'h00};
    end
  end

endmodule // iprc_priority_bank

// >>> tb.sv
// Bench: APB master and reference levels against the bank.
// Assumes the checker is bound to the bank.
`timescale 1ns/1ps
module tb;
  logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, take = 0, pready, pslverr, win_valid_r;
  logic [4:0] win_id_r;
  logic [7:0] win_level_r;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, irq_enable = 32'h0, raise = 32'h0, prdata, irq_pending, r, d;
  logic [1:0] lvl [32] = '{default: 2'h0};
  int miscompares = 0, total_checks = 0;
  always #10 clk = ~clk;
  iprc_priority_bank i_iprc_priority_bank (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq_enable, .irq_pending, .win_valid_r, .win_id_r, .win_level_r);
  iprc_core_model i_iprc_core_model (.clk, .take, .raise, .win_valid_r, .win_id_r, .irq_pending);
  task automatic chk(input logic [31:0] s, x);
    total_checks++;
    if (s !== x) begin
      miscompares++;
      $display("mismatch %0t %h %h", $time, s, x);
    end
  endtask
  // APB transfer, full words only, held until pready is seen high
  task automatic ap(input logic w, input int a, input logic [31:0] v);
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a[11:0], v};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    {psel, penable} <= 2'h0;
    chk(pslverr, a < 'h400 || a > 'h420 || a % 4);
  endtask
  // Check group g, then give it a random word
  task automatic put(input int g);
    for (int i = 0; i < 4; i++) d[8 * i +: 8] = {lvl[4 * g + i], 6'h0};
    ap(1'b0, 'h400 + 4 * g, 32'h0);
    chk(r, d);
    d = $urandom & 32'hC0C0C0C0;
    ap(1'b1, 'h400 + 4 * g, d);
    for (int i = 0; i < 4; i++) lvl[4 * g + i] = d[8 * i + 6 +: 2];
  endtask
  // Lowest level wins, ties go to the lowest number
  function automatic logic [13:0] best(input logic [31:0] p);
    int b = -1;
    for (int i = 31; i >= 0; i--) if (p[i] && (b < 0 || lvl[i] <= lvl[b])) b = i;
    return b < 0 ? 14'h0 : {1'b1, lvl[b], 6'h0, b[4:0]};
  endfunction
  task automatic test_done;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog far past the run of about six hundred cycles
  initial begin
    #200000;
    miscompares++;
    test_done;
  end
  initial begin
    void'($urandom(88));
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    // Misaligned write must not reach group 0
    ap(1'b1, 'h402, 32'hFFFFFFFF);
    ap(1'b0, 'h424, 32'h0);
    for (int k = 0; k < 8; k++) put(k);
    $display("test regs done");
    // Random levels and requests; the core takes some winners
    repeat (40) begin
      put($urandom % 8);
      irq_enable <= $urandom;
      raise <= $urandom & $urandom & $urandom;
      take <= $urandom % 2;
      @(posedge clk);
      raise <= 32'h0;
      take <= 1'b0;
      repeat (3) @(posedge clk);
      chk({win_valid_r, win_valid_r ? {win_level_r, win_id_r} : 13'h0}, best(irq_enable & irq_pending));
      d = best(irq_enable & irq_pending);
      ap(1'b0, 'h420, 32'h0);
      chk(r, {d[13], 15'h0, d[12:5], 3'h0, d[4:0]});
    end
    $display("test winner done");
    test_done;
  end
endmodule // tb
